// file: common/mtcsr_pkg.sv
/*
  Package for the machine trap-setup register bank: CSR addresses, field positions,
  reset values and bus constants. Assumes a 12-bit CSR address held in the register index.
*/
package mtcsr_pkg;
  localparam logic [11:0] CSR_FP_FLAGS = 12'h001;
  localparam logic [11:0] CSR_FP_RMODE = 12'h002;
  localparam logic [11:0] CSR_FP_CTRL = 12'h003;
  localparam logic [11:0] CSR_STATUS = 12'h300;
  localparam logic [11:0] CSR_ISA = 12'h301;
  localparam logic [11:0] CSR_IRQ_EN = 12'h304;
  localparam logic [11:0] CSR_TVEC = 12'h305;
  localparam logic [11:0] CSR_CNT_ACC = 12'h306;
  localparam logic [11:0] CSR_ENV_LO = 12'h30A;
  localparam logic [11:0] CSR_ENV_HI = 12'h31A;
  // Control registers of this bank, placed at the top of the 12-bit CSR space.
  localparam logic [11:0] CSR_CTRL = 12'hFFE;
  localparam logic [11:0] CSR_STAT = 12'hFFF;

  localparam int FLAGS_W = 5;
  localparam int RMODE_W = 3;
  localparam int ST_WAIT_TO = 21;
  localparam int ST_PP_HI = 12;
  localparam int ST_PP_LO = 11;
  localparam int ST_PGE = 7;
  localparam int ST_GE = 3;
  localparam int ISA_MXL_HI = 31;
  localparam int ISA_MXL_LO = 30;
  localparam int ISA_X = 23;
  localparam int ISA_U = 20;
  localparam int ISA_M = 12;
  localparam int ISA_I = 8;
  localparam int ISA_E = 4;
  localparam int ISA_C = 2;
  localparam logic [1:0] MXL_32 = 2'h1;
  localparam int IE_FAST_HI = 31;
  localparam int IE_FAST_LO = 16;
  localparam int IE_EXT = 11;
  localparam int IE_TMR = 7;
  localparam int IE_SW = 3;
  localparam int TV_BASE_LO = 2;
  localparam int CA_W = 3;
  localparam int CA_CYCLE = 2;
  localparam int CA_TIME = 1;
  localparam int CA_RETIRED = 0;
  localparam logic [1:0] PRIV_MACHINE = 2'h3;
  localparam logic [1:0] PRIV_USER = 2'h0;
  localparam logic [31:0] ZERO32 = 32'h00000000;
  // Counter window for user-read checks: the upper CSR address bits and the low index.
  localparam logic [11:0] CNT_USER_BASE = 12'hC00;
  localparam logic [11:0] CNT_USER_MASK = 12'hF60;
  // Control register fields.
  localparam int CT_TRAP = 0;
  localparam int CT_RET = 1;
  localparam int CT_CHECK = 2;
  localparam int CT_WFI = 3;
endpackage : mtcsr_pkg

// file: verilog/mtcsr_bank.sv
/*
  Machine trap-setup CSR bank: floating-point, environment and trap-setup registers
  reached over an Avalon-MM slave whose word index is the CSR address.
  Assumes the pipeline drives the trap, return and check strobes on the same clock.
*/
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module mtcsr_bank #(
  parameter bit OPTION_FLOAT_IN_INT_REGS = 1'b1,
  parameter bit OPTION_USER_MODE = 1'b1,
  parameter bit OPTION_MUL_DIV = 1'b1,
  parameter bit OPTION_EMBEDDED = 1'b0,
  parameter bit OPTION_COMPRESSED = 1'b1
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [11:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic [1:0] AVS_RESPONSE,
  output logic AVS_WAITREQUEST,
  input wire logic [15:0] FAST_IRQ_PEND,
  input wire logic EXT_IRQ_PEND,
  input wire logic TMR_IRQ_PEND,
  input wire logic SW_IRQ_PEND,
  input wire logic [mtcsr_pkg::FLAGS_W-1:0] FP_FLAGS_SET,
  output logic IRQ_TAKE,
  output logic [31:0] TRAP_BASE,
  output logic [1:0] PRIV_LEVEL,
  output logic [2:0] RMODE,
  output logic ILLEGAL
);
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // Whether an address names a register that exists in this build.
  function automatic logic csr_exists(input logic [11:0] a);
    case (a)
      mtcsr_pkg::CSR_FP_FLAGS, mtcsr_pkg::CSR_FP_RMODE, mtcsr_pkg::CSR_FP_CTRL:
        return OPTION_FLOAT_IN_INT_REGS;
      mtcsr_pkg::CSR_ENV_LO, mtcsr_pkg::CSR_ENV_HI: return OPTION_USER_MODE;
      mtcsr_pkg::CSR_CNT_ACC: return OPTION_USER_MODE;
      mtcsr_pkg::CSR_STATUS, mtcsr_pkg::CSR_ISA, mtcsr_pkg::CSR_IRQ_EN, mtcsr_pkg::CSR_TVEC,
      mtcsr_pkg::CSR_CTRL, mtcsr_pkg::CSR_STAT: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : csr_exists

  ////////////////////////////////////////////////////////////////////////////////
  logic [4:0] flags_q;
  logic [2:0] rmode_q;
  logic wait_to_q;
  logic [1:0] prev_priv_q;
  logic prev_ge_q;
  logic ge_q;
  logic [1:0] priv_q;
  logic [31:0] irq_en_q;
  logic [29:0] tvec_q;
  logic [2:0] cnt_acc_q;
  logic [3:0] ctrl_q;
  logic [1:0] cnt_idx_q;
  logic illegal_q;
  logic [31:0] st_wr_v;
  logic [31:0] ie_wr_v;
  logic [31:0] tv_wr_v;
  logic [31:0] ca_wr_v;
  logic [31:0] rdata_q;
  logic [1:0] resp_q;
  logic ack_q;
  logic [31:0] status_v;
  logic [31:0] isa_v;
  logic [31:0] wdata_v;
  logic req;
  logic wr_fire;
  logic trap_ev;
  logic ret_ev;
  logic pend_any;

  assign req = (AVS_READ | AVS_WRITE) & CE;
  // One wait state: the answer comes the cycle after the request is seen.
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
  assign wr_fire = AVS_WRITE & ack_q & CE;
  assign AVS_READDATA = rdata_q;
  assign AVS_RESPONSE = resp_q;
  assign wdata_v = AVS_WRITEDATA;
  // Byte-merged write values for status, enables, vector and counter access; FP and control writes take the whole word.
  assign st_wr_v = be_merge(status_v, wdata_v, AVS_BYTEENABLE);
  assign ie_wr_v = be_merge(irq_en_q, wdata_v, AVS_BYTEENABLE);
  assign tv_wr_v = be_merge({tvec_q, 2'h0}, wdata_v, AVS_BYTEENABLE);
  assign ca_wr_v = be_merge({29'h0, cnt_acc_q}, wdata_v, AVS_BYTEENABLE);

  always_comb begin
    status_v = mtcsr_pkg::ZERO32;
    status_v[mtcsr_pkg::ST_WAIT_TO] = wait_to_q & OPTION_USER_MODE;
    status_v[mtcsr_pkg::ST_PP_HI:mtcsr_pkg::ST_PP_LO] = prev_priv_q;
    status_v[mtcsr_pkg::ST_PGE] = prev_ge_q;
    status_v[mtcsr_pkg::ST_GE] = ge_q;
  end

  always_comb begin
    isa_v = mtcsr_pkg::ZERO32;
    isa_v[mtcsr_pkg::ISA_MXL_HI:mtcsr_pkg::ISA_MXL_LO] = mtcsr_pkg::MXL_32;
    isa_v[mtcsr_pkg::ISA_X] = 1'b1;
    isa_v[mtcsr_pkg::ISA_U] = OPTION_USER_MODE;
    isa_v[mtcsr_pkg::ISA_M] = OPTION_MUL_DIV;
    isa_v[mtcsr_pkg::ISA_I] = ~OPTION_EMBEDDED;
    isa_v[mtcsr_pkg::ISA_E] = OPTION_EMBEDDED;
    isa_v[mtcsr_pkg::ISA_C] = OPTION_COMPRESSED;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus answer and read mux.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ack_q <= 1'b0;
      rdata_q <= mtcsr_pkg::ZERO32;
      resp_q <= 2'h0;
    end else if (CE) begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) begin
        resp_q <= csr_exists(AVS_ADDRESS) ? 2'h0 : 2'h2;
        rdata_q <= mtcsr_pkg::ZERO32;
        if (AVS_READ) begin
          case (AVS_ADDRESS)
            mtcsr_pkg::CSR_FP_FLAGS: rdata_q <= OPTION_FLOAT_IN_INT_REGS ? {27'h0, flags_q} : 32'h0;
            mtcsr_pkg::CSR_FP_RMODE: rdata_q <= OPTION_FLOAT_IN_INT_REGS ? {29'h0, rmode_q} : 32'h0;
            mtcsr_pkg::CSR_FP_CTRL: rdata_q <= OPTION_FLOAT_IN_INT_REGS ? {24'h0, rmode_q, flags_q} : 32'h0;
            mtcsr_pkg::CSR_STATUS: rdata_q <= status_v;
            mtcsr_pkg::CSR_ISA: rdata_q <= isa_v;
            mtcsr_pkg::CSR_IRQ_EN: rdata_q <= irq_en_q;
            mtcsr_pkg::CSR_TVEC: rdata_q <= {tvec_q, 2'h0};
            mtcsr_pkg::CSR_CNT_ACC: rdata_q <= OPTION_USER_MODE ? {29'h0, cnt_acc_q} : 32'h0;
            mtcsr_pkg::CSR_ENV_LO, mtcsr_pkg::CSR_ENV_HI: rdata_q <= mtcsr_pkg::ZERO32;
            mtcsr_pkg::CSR_CTRL: rdata_q <= {28'h0, ctrl_q};
            mtcsr_pkg::CSR_STAT: rdata_q <= {28'h0, illegal_q, pend_any, priv_q};
            default: rdata_q <= mtcsr_pkg::ZERO32;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control strobes written by the pipeline: trap entry, return, and user checks.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ctrl_q <= 4'h0;
      cnt_idx_q <= 2'h0;
    end else if (CE) begin
      ctrl_q <= 4'h0;
      if (wr_fire && AVS_ADDRESS == mtcsr_pkg::CSR_CTRL) begin
        ctrl_q <= wdata_v[3:0];
        // The counter index is kept because the write data is gone when the check runs.
        cnt_idx_q <= wdata_v[1:0];
      end
    end
  end

  assign trap_ev = ctrl_q[mtcsr_pkg::CT_TRAP] | IRQ_TAKE;
  assign ret_ev = ctrl_q[mtcsr_pkg::CT_RET] & ~trap_ev;

  assign pend_any = |({FAST_IRQ_PEND, 4'h0, EXT_IRQ_PEND, 3'h0, TMR_IRQ_PEND, 3'h0, SW_IRQ_PEND, 3'h0} & irq_en_q);
  assign IRQ_TAKE = pend_any & ge_q;

  // Illegal flag: user counter read without permit, wfi blocked in user mode, or a bus access to an address that does not exist.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      illegal_q <= 1'b0;
    end else if (CE) begin
      if (ctrl_q[mtcsr_pkg::CT_CHECK] && priv_q == mtcsr_pkg::PRIV_USER) begin
        illegal_q <= (cnt_idx_q == 2'h3) ? 1'b1 : (~cnt_acc_q[cnt_idx_q] | ~OPTION_USER_MODE);
      end else if (ctrl_q[mtcsr_pkg::CT_WFI] && priv_q == mtcsr_pkg::PRIV_USER) begin
        illegal_q <= wait_to_q;
      end else if (req & ~ack_q) begin
        illegal_q <= ~csr_exists(AVS_ADDRESS);
      end
    end
  end
  assign ILLEGAL = illegal_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Status register.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      wait_to_q <= 1'b0;
      prev_priv_q <= mtcsr_pkg::PRIV_USER;
      prev_ge_q <= 1'b0;
      ge_q <= 1'b0;
      priv_q <= mtcsr_pkg::PRIV_MACHINE;
    end else if (CE) begin
      if (trap_ev) begin
        prev_ge_q <= ge_q;
        ge_q <= 1'b0;
        prev_priv_q <= priv_q;
        priv_q <= mtcsr_pkg::PRIV_MACHINE;
      end else if (ret_ev) begin
        ge_q <= prev_ge_q;
        priv_q <= OPTION_USER_MODE ? prev_priv_q : mtcsr_pkg::PRIV_MACHINE;
      end else if (wr_fire && AVS_ADDRESS == mtcsr_pkg::CSR_STATUS) begin
        wait_to_q <= st_wr_v[mtcsr_pkg::ST_WAIT_TO] & OPTION_USER_MODE;
        prev_priv_q <= st_wr_v[mtcsr_pkg::ST_PP_HI:mtcsr_pkg::ST_PP_LO];
        prev_ge_q <= st_wr_v[mtcsr_pkg::ST_PGE];
        ge_q <= st_wr_v[mtcsr_pkg::ST_GE];
      end
    end
  end
  assign PRIV_LEVEL = priv_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Enables, vector and counter access. Reset values are arbitrary for undefined ones.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      irq_en_q <= mtcsr_pkg::ZERO32;
      tvec_q <= 30'h0;
      cnt_acc_q <= 3'h0;
    end else if (CE && wr_fire) begin
      if (AVS_ADDRESS == mtcsr_pkg::CSR_IRQ_EN) begin
        irq_en_q <= {ie_wr_v[mtcsr_pkg::IE_FAST_HI:mtcsr_pkg::IE_FAST_LO], 4'h0,
                     ie_wr_v[mtcsr_pkg::IE_EXT], 3'h0,
                     ie_wr_v[mtcsr_pkg::IE_TMR], 3'h0,
                     ie_wr_v[mtcsr_pkg::IE_SW], 3'h0};
      end
      if (AVS_ADDRESS == mtcsr_pkg::CSR_TVEC) begin
        tvec_q <= tv_wr_v[31:mtcsr_pkg::TV_BASE_LO];
      end
      if (AVS_ADDRESS == mtcsr_pkg::CSR_CNT_ACC && OPTION_USER_MODE) begin
        cnt_acc_q <= ca_wr_v[mtcsr_pkg::CA_W-1:0];
      end
    end
  end
  assign TRAP_BASE = {tvec_q, 2'h0};

  ////////////////////////////////////////////////////////////////////////////////
  // Floating-point flags and rounding mode; hardware flag sets win over a write.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      flags_q <= 5'h0;
      rmode_q <= 3'h0;
    end else if (CE && OPTION_FLOAT_IN_INT_REGS) begin
      if (wr_fire && AVS_ADDRESS == mtcsr_pkg::CSR_FP_FLAGS) begin
        flags_q <= wdata_v[mtcsr_pkg::FLAGS_W-1:0] | FP_FLAGS_SET;
      end else if (wr_fire && AVS_ADDRESS == mtcsr_pkg::CSR_FP_CTRL) begin
        flags_q <= wdata_v[mtcsr_pkg::FLAGS_W-1:0] | FP_FLAGS_SET;
      end else begin
        flags_q <= flags_q | FP_FLAGS_SET;
      end
      if (wr_fire && AVS_ADDRESS == mtcsr_pkg::CSR_FP_RMODE) begin
        rmode_q <= wdata_v[mtcsr_pkg::RMODE_W-1:0];
      end else if (wr_fire && AVS_ADDRESS == mtcsr_pkg::CSR_FP_CTRL) begin
        rmode_q <= wdata_v[mtcsr_pkg::FLAGS_W +: mtcsr_pkg::RMODE_W];
      end
    end
  end
  assign RMODE = rmode_q;
  // The ISA register has no write path at all, so writes are dropped without a fault.
endmodule : mtcsr_bank

// file: tb/mtcsr_cpu_model.sv
/* CPU pipeline model that issues CSR reads and writes as an Avalon-MM master.
   Assumes the bank drives waitrequest, readdata and response on the same clock. */
`timescale 1ns/1ps
module mtcsr_cpu_model (
  input wire logic MCLK,
  input wire logic AVS_WAITREQUEST,
  input wire logic [31:0] AVS_READDATA,
  input wire logic [1:0] AVS_RESPONSE,
  output logic [11:0] AVS_ADDRESS,
  output logic AVS_READ,
  output logic AVS_WRITE,
  output logic [31:0] AVS_WRITEDATA,
  output logic [3:0] AVS_BYTEENABLE
);
  initial begin
    AVS_ADDRESS = 12'h000;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = 32'h00000000;
    AVS_BYTEENABLE = 4'hF;
  end
  // The idle bus shows inverted values so the bank cannot lean on a stale address or data word.
  task automatic access(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge MCLK);
    AVS_ADDRESS <= addr;
    AVS_WRITEDATA <= wdata;
    AVS_READ <= !wr;
    AVS_WRITE <= wr;
    do begin
      @(posedge MCLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 200);
    rdata = AVS_READDATA;
    resp = AVS_RESPONSE;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    AVS_ADDRESS <= ~addr;
    AVS_WRITEDATA <= ~wdata;
  endtask : access
endmodule : mtcsr_cpu_model

// file: tb/mtcsr_props.sv
/* Checker for the CSR bank, watching only the top-level ports.
   Assumes one clock and an active-high asynchronous reset. */
`timescale 1ns/1ps
module mtcsr_props (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [11:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic [31:0] AVS_READDATA,
  input wire logic [1:0] AVS_RESPONSE,
  input wire logic AVS_WAITREQUEST,
  input wire logic [15:0] FAST_IRQ_PEND,
  input wire logic EXT_IRQ_PEND,
  input wire logic TMR_IRQ_PEND,
  input wire logic SW_IRQ_PEND,
  input wire logic IRQ_TAKE,
  input wire logic [31:0] TRAP_BASE,
  input wire logic [2:0] RMODE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  logic rd_ok;
  assign rd_ok = AVS_READ && !AVS_WAITREQUEST && AVS_RESPONSE == 2'h0;
  ////////////////////////////////////////////////////////////////////////////////
  property p_flags_rd; rd_ok && AVS_ADDRESS == mtcsr_pkg::CSR_FP_FLAGS |-> AVS_READDATA[31:5] == 27'h0; endproperty
  a_flags_rd: assert property (p_flags_rd) else $error("flags read has high bits");
  property p_rmode_rd; rd_ok && AVS_ADDRESS == mtcsr_pkg::CSR_FP_RMODE |-> AVS_READDATA == {29'h0, RMODE}; endproperty
  a_rmode_rd: assert property (p_rmode_rd) else $error("rounding mode read differs from output");
  property p_stat_rd; rd_ok && AVS_ADDRESS == mtcsr_pkg::CSR_STATUS |-> (AVS_READDATA & ~32'h00201888) == 32'h0; endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status unused bit set");
  property p_isa_rd; rd_ok && AVS_ADDRESS == mtcsr_pkg::CSR_ISA |-> AVS_READDATA[31:30] == 2'h1 && AVS_READDATA[23]; endproperty
  a_isa_rd: assert property (p_isa_rd) else $error("isa width or custom bit wrong");
  property p_ie_rd; rd_ok && AVS_ADDRESS == mtcsr_pkg::CSR_IRQ_EN |-> (AVS_READDATA & 32'h0000F777) == 32'h0; endproperty
  a_ie_rd: assert property (p_ie_rd) else $error("interrupt enable unused bit set");
  property p_cnt_rd; rd_ok && AVS_ADDRESS == mtcsr_pkg::CSR_CNT_ACC |-> AVS_READDATA[31:3] == 29'h0; endproperty
  a_cnt_rd: assert property (p_cnt_rd) else $error("counter access high bits set");
  property p_env_rd; rd_ok && (AVS_ADDRESS == mtcsr_pkg::CSR_ENV_LO || AVS_ADDRESS == mtcsr_pkg::CSR_ENV_HI) |->
    AVS_READDATA == 32'h0; endproperty
  a_env_rd: assert property (p_env_rd) else $error("environment register not zero");
  property p_irq_gate; IRQ_TAKE |-> (|FAST_IRQ_PEND) || EXT_IRQ_PEND || TMR_IRQ_PEND || SW_IRQ_PEND; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt taken with nothing pending");
  property p_trap_clr; IRQ_TAKE |=> !IRQ_TAKE; endproperty
  a_trap_clr: assert property (p_trap_clr) else $error("global enable not cleared on trap");
  property p_tvec_rd; rd_ok && AVS_ADDRESS == mtcsr_pkg::CSR_TVEC |-> AVS_READDATA == TRAP_BASE && TRAP_BASE[1:0] == 2'h0;
  endproperty
  a_tvec_rd: assert property (p_tvec_rd) else $error("trap vector read or alignment wrong");
endmodule : mtcsr_props
bind mtcsr_bank mtcsr_props props_u (.MCLK(MCLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_READDATA(AVS_READDATA), .AVS_RESPONSE(AVS_RESPONSE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .FAST_IRQ_PEND(FAST_IRQ_PEND), .EXT_IRQ_PEND(EXT_IRQ_PEND), .TMR_IRQ_PEND(TMR_IRQ_PEND),
  .SW_IRQ_PEND(SW_IRQ_PEND), .IRQ_TAKE(IRQ_TAKE), .TRAP_BASE(TRAP_BASE), .RMODE(RMODE));

// file: tb/tb_machine_trap_setup_csr_bank.sv
/* Self-checking bench for the CSR bank, driving it through the CPU model's bus task.
   Assumes the bank's default build options. */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin bad_count++; $display("BAD %s expected %h seen %h", nm, exp, got); end end
module tb_machine_trap_setup_csr_bank;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic TMR_IRQ_PEND = 1'b0;
  logic [11:0] AVS_ADDRESS;
  logic AVS_READ, AVS_WRITE, AVS_WAITREQUEST, IRQ_TAKE, ILLEGAL;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, TRAP_BASE, rdata;
  logic [3:0] AVS_BYTEENABLE;
  logic [1:0] AVS_RESPONSE, PRIV_LEVEL, resp;
  logic [2:0] RMODE;
  int checks = 0;
  int bad_count = 0;
  localparam logic [31:0] ISA_EXP = (32'(mtcsr_pkg::MXL_32) << 30) | (32'h1 << mtcsr_pkg::ISA_X) |
    (32'h1 << mtcsr_pkg::ISA_U) | (32'h1 << mtcsr_pkg::ISA_M) | (32'h1 << mtcsr_pkg::ISA_I) | (32'h1 << mtcsr_pkg::ISA_C);
  logic [11:0] t_addr [7] = '{mtcsr_pkg::CSR_ENV_LO, mtcsr_pkg::CSR_STATUS, mtcsr_pkg::CSR_IRQ_EN, mtcsr_pkg::CSR_TVEC,
    mtcsr_pkg::CSR_CNT_ACC, mtcsr_pkg::CSR_FP_FLAGS, mtcsr_pkg::CSR_FP_RMODE};
  logic [31:0] t_mask [7] = '{32'h0, 32'h00201888, 32'hFFFF0888, 32'hFFFFFFFC, 32'h7, 32'h1F, 32'h7};
  always #20 MCLK = ~MCLK;
  mtcsr_cpu_model cpu_u (.MCLK(MCLK), .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_READDATA(AVS_READDATA),
    .AVS_RESPONSE(AVS_RESPONSE), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE));
  mtcsr_bank dut_u (.MCLK(MCLK), .RST(RST), .CE(1'b1), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_RESPONSE(AVS_RESPONSE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .FAST_IRQ_PEND(16'h0000), .EXT_IRQ_PEND(1'b0), .TMR_IRQ_PEND(TMR_IRQ_PEND), .SW_IRQ_PEND(1'b0),
    .FP_FLAGS_SET(5'h00), .IRQ_TAKE(IRQ_TAKE), .TRAP_BASE(TRAP_BASE), .PRIV_LEVEL(PRIV_LEVEL), .RMODE(RMODE),
    .ILLEGAL(ILLEGAL));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    cpu_u.access(1'b1, a, d, rdata, resp);
  endtask : wr
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    cpu_u.access(1'b0, a, 32'h00000000, rdata, resp);
    `CHK($sformatf("csr %h", a), exp, rdata)
  endtask : rd_chk
  task automatic tally_and_finish;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (5000) @(posedge MCLK);
    bad_count++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge MCLK);
    RST <= 1'b0;
    rd_chk(mtcsr_pkg::CSR_STATUS, 32'h0);
    rd_chk(mtcsr_pkg::CSR_ENV_HI, 32'h0);
    `CHK("priv", mtcsr_pkg::PRIV_MACHINE, PRIV_LEVEL)
    wr(mtcsr_pkg::CSR_ISA, 32'hFFFFFFFF);
    `CHK("isa write resp", 2'h0, resp)
    rd_chk(mtcsr_pkg::CSR_ISA, ISA_EXP);
    // Writing all ones exposes every bit that must stay zero.
    for (int i = 0; i < 7; i++) begin
      wr(t_addr[i], 32'hFFFFFFFF);
      rd_chk(t_addr[i], t_mask[i]);
    end
    rd_chk(mtcsr_pkg::CSR_FP_CTRL, 32'h000000FF);
    `CHK("trap base", 32'hFFFFFFFC, TRAP_BASE)
    `CHK("rmode", 3'h7, RMODE)
    wr(mtcsr_pkg::CSR_FP_CTRL, 32'h00000045);
    rd_chk(mtcsr_pkg::CSR_FP_FLAGS, 32'h5);
    rd_chk(mtcsr_pkg::CSR_FP_RMODE, 32'h2);
    wr(mtcsr_pkg::CSR_STATUS, 32'h0);
    TMR_IRQ_PEND <= 1'b1;
    @(negedge MCLK);
    `CHK("irq without global enable", 1'b0, IRQ_TAKE)
    // Setting the global enable with the timer pending starts a trap at once.
    wr(mtcsr_pkg::CSR_STATUS, 32'h00000008);
    // Keep the timer pending through the edge at which the trap is taken.
    @(posedge MCLK);
    TMR_IRQ_PEND <= 1'b0;
    rd_chk(mtcsr_pkg::CSR_STATUS, 32'h00001880);
    wr(mtcsr_pkg::CSR_STATUS, 32'h00200080);
    wr(mtcsr_pkg::CSR_CTRL, 32'h00000002);
    cpu_u.access(1'b0, mtcsr_pkg::CSR_STATUS, 32'h0, rdata, resp);
    `CHK("enable after return", 1'b1, rdata[mtcsr_pkg::ST_GE])
    `CHK("priv after return", mtcsr_pkg::PRIV_USER, PRIV_LEVEL)
    wr(mtcsr_pkg::CSR_CNT_ACC, 32'h00000006);
    wr(mtcsr_pkg::CSR_CTRL, 32'h00000004);
    @(posedge MCLK);
    @(negedge MCLK);
    `CHK("user counter read refused", 1'b1, ILLEGAL)
    wr(mtcsr_pkg::CSR_CTRL, 32'h00000008);
    @(posedge MCLK);
    @(negedge MCLK);
    `CHK("user wfi blocked", 1'b1, ILLEGAL)
    cpu_u.access(1'b0, 12'h7FF, 32'h0, rdata, resp);
    `CHK("unmapped resp", 2'h2, resp)
    `CHK("unmapped illegal", 1'b1, ILLEGAL)
    tally_and_finish();
  end
endmodule : tb_machine_trap_setup_csr_bank
